// ==== ghc_defs.vh ====
`ifndef GHC_DEFS_VH
`define GHC_DEFS_VH
// configuration space offsets
`define GHC_CFG_ID_OFS      8'h00
`define GHC_CFG_FB_OFS      8'h10
`define GHC_CFG_MMIO_OFS    8'h14
`define GHC_CFG_SPEED_OFS   8'h50
// fields of the memory speed register
`define GHC_SPEED_FREQ_BIT  4
`define GHC_SPEED_AP64_BIT  0
`define GHC_SPEED_RST       8'h00
// register window
`define GHC_MMIO_SIZE       32'h0008_0000
`define GHC_MMIO_BASE_LSB   19
`define GHC_RING_OFS        19'h0_2030
`define GHC_CURSOR_OFS      19'h7_0084
`define GHC_WIN_RST         32'h0000_0000
// frame buffer aperture sizes
`define GHC_FB32_LSB        25
`define GHC_FB64_LSB        26
// legacy ports
`define GHC_MISC_WR_PORT    16'h03c2
`define GHC_MISC_RD_PORT    16'h03cc
`define GHC_MONO_IDX_PORT   16'h03b4
`define GHC_MONO_DAT_PORT   16'h03b5
`define GHC_MONO_STS_PORT   16'h03ba
`define GHC_COLR_IDX_PORT   16'h03d4
`define GHC_COLR_DAT_PORT   16'h03d5
`define GHC_COLR_STS_PORT   16'h03da
`define GHC_MISC_RST        8'h00
`define GHC_IDX_RST         8'h00
`define GHC_CRT_RST         8'h00
// display controller indexes
`define GHC_VSYNC_END_IDX   5'h11
`define GHC_PROTECT_BIT     7
`define GHC_PROT_LAST_IDX   5'h07
`endif

// ==== ghc_host_cfg.v ====
// Contract
// - misc bit0 low selects 3B4/3B5/3BA ports
// - misc bit0 high selects 3D4/3D5/3DA ports
// - unlock by clearing vsync-end high bit
// - config 0x50 bit4 reports memory frequency
// - 0x80000-byte window based at config 0x14
// - frame buffer aperture of 32 or 64 MB
// - cursor base used untranslated, at 70084h
// - ring pointers consecutive from 2030h
// - read-only vendor and device identifiers
`timescale 1ns/10ps
`default_nettype none
`include "ghc_defs.vh"

module ghc_host_cfg #(
  parameter [15:0] VENDOR_ID = 16'h1d0e, // arbitrary value
  parameter [15:0] DEVICE_ID = 16'h0a01, // arbitrary value
  parameter        CRT_REGS  = 32
) (
  // clock and reset
  input  wire        MCLK,
  input  wire        SYS_RST,
  // configuration space access
  input  wire [7:0]  CFG_ADDR,
  input  wire        CFG_WR,
  input  wire        CFG_RD,
  input  wire [31:0] CFG_WDATA,
  output reg  [31:0] CFG_RDATA,
  output reg         CFG_RVALID,
  // legacy io port access
  input  wire [15:0] IO_ADDR,
  input  wire        IO_WR,
  input  wire        IO_RD,
  input  wire [7:0]  IO_WDATA,
  output reg  [7:0]  IO_RDATA,
  output reg         IO_RVALID,
  output wire        IO_HIT,
  input  wire [7:0]  DISP_STATUS,
  // memory access
  input  wire [31:0] MEM_ADDR,
  input  wire        MEM_WR,
  input  wire        MEM_RD,
  input  wire [31:0] MEM_WDATA,
  output reg  [31:0] MEM_RDATA,
  output reg         MEM_RVALID,
  output wire        MMIO_HIT,
  output wire        FB_HIT,
  output wire [25:0] FB_OFFSET,
  // strap and display outputs
  input  wire        MEM_FREQ_133,
  output wire [31:0] CURSOR_FETCH_ADDR,
  output wire        COLOR_MODE,
  output wire [7:0]  CRT_TIMING_0
);

  // ------------------------------------------------------------
  // strap synchroniser
  // ------------------------------------------------------------
  // first and second synchroniser stages
  reg freq_s1_q;
  reg freq_s2_q;

  // two flops before anything reads the pin
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      freq_s1_q <= 1'b0;
      freq_s2_q <= 1'b0;
    end else begin
      freq_s1_q <= MEM_FREQ_133;
      freq_s2_q <= freq_s1_q;
    end
  end

  // ------------------------------------------------------------
  // configuration space
  // ------------------------------------------------------------
  // writable bases, speed byte and its read view
  reg  [31:`GHC_MMIO_BASE_LSB] mmio_base_q;
  reg  [31:`GHC_FB32_LSB]      fb_base_q;
  reg  [7:0]                   speed_q;
  wire [7:0]                   speed_rd;
  wire                         ap64;

  assign ap64 = speed_q[`GHC_SPEED_AP64_BIT];

  // bit4 always shows the strap, software cannot change it
  assign speed_rd = {speed_q[7:5], freq_s2_q, speed_q[3:0]};

  // writable config fields
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      mmio_base_q <= {(32-`GHC_MMIO_BASE_LSB){1'b0}};
      fb_base_q   <= {(32-`GHC_FB32_LSB){1'b0}};
      speed_q     <= `GHC_SPEED_RST;
    end else if (CFG_WR) begin
      case (CFG_ADDR)
        `GHC_CFG_MMIO_OFS: begin
          mmio_base_q <= CFG_WDATA[31:`GHC_MMIO_BASE_LSB];
        end
        `GHC_CFG_FB_OFS: begin
          fb_base_q <= CFG_WDATA[31:`GHC_FB32_LSB];
        end
        `GHC_CFG_SPEED_OFS: begin
          speed_q <= CFG_WDATA[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // config read data, one cycle after the strobe
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      CFG_RDATA  <= 32'h0000_0000;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD) begin
        case (CFG_ADDR)
          `GHC_CFG_ID_OFS: begin
            CFG_RDATA <= {DEVICE_ID, VENDOR_ID};
          end
          `GHC_CFG_MMIO_OFS: begin
            CFG_RDATA <= {mmio_base_q, {`GHC_MMIO_BASE_LSB{1'b0}}};
          end
          `GHC_CFG_FB_OFS: begin
            // lowest base bit reads zero in 64 MB mode
            CFG_RDATA <= {fb_base_q[31:`GHC_FB64_LSB], fb_base_q[`GHC_FB32_LSB] & ~ap64,
                          {`GHC_FB32_LSB{1'b0}}};
          end
          `GHC_CFG_SPEED_OFS: begin
            CFG_RDATA <= {24'h00_0000, speed_rd};
          end
          default: begin
            CFG_RDATA <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // legacy io ports
  // ------------------------------------------------------------
  // misc output, display index and port decodes
  reg  [7:0] misc_q;
  reg  [7:0] crt_idx_q;
  wire       color;
  wire       idx_hit;
  wire       dat_hit;
  wire       sts_hit;
  wire       protect;
  wire       idx_ok;
  wire [7:0] crt_rd;

  // decodes follow the colour bit; misc ports always answer
  assign color   = misc_q[0];
  assign idx_hit = color ? (IO_ADDR == `GHC_COLR_IDX_PORT) : (IO_ADDR == `GHC_MONO_IDX_PORT);
  assign dat_hit = color ? (IO_ADDR == `GHC_COLR_DAT_PORT) : (IO_ADDR == `GHC_MONO_DAT_PORT);
  assign sts_hit = color ? (IO_ADDR == `GHC_COLR_STS_PORT) : (IO_ADDR == `GHC_MONO_STS_PORT);
  assign idx_ok  = (crt_idx_q < CRT_REGS);
  assign IO_HIT  = idx_hit | dat_hit | sts_hit | (IO_ADDR == `GHC_MISC_WR_PORT) |
                   (IO_ADDR == `GHC_MISC_RD_PORT);
  assign COLOR_MODE = color;

  // misc output and index registers
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      misc_q    <= `GHC_MISC_RST;
      crt_idx_q <= `GHC_IDX_RST;
    end else if (IO_WR) begin
      if (IO_ADDR == `GHC_MISC_WR_PORT) begin
        misc_q <= IO_WDATA;
      end
      if (idx_hit) begin
        crt_idx_q <= IO_WDATA;
      end
    end
  end

  // ------------------------------------------------------------
  // display controller register file
  // ------------------------------------------------------------
  // read view of every display register
  wire [7:0] crt_val [0:CRT_REGS-1];

  genvar gi;
  generate
    for (gi = 0; gi < CRT_REGS; gi = gi + 1) begin : g_crt
      reg  [7:0] val_q;
      wire       sel;
      wire       locked;
      assign sel    = IO_WR & dat_hit & (crt_idx_q == gi);
      // timing indexes refuse writes while the protect bit is set
      assign locked = protect & (gi <= `GHC_PROT_LAST_IDX);
      always @(posedge MCLK) begin
        if (SYS_RST) begin
          val_q <= `GHC_CRT_RST;
        end else if (sel & ~locked) begin
          val_q <= IO_WDATA;
        end
      end
      assign crt_val[gi] = val_q;
    end
  endgenerate

  // protect bit, data port read view and timing register 0 out
  assign protect      = crt_val[`GHC_VSYNC_END_IDX][`GHC_PROTECT_BIT];
  assign crt_rd       = idx_ok ? crt_val[crt_idx_q[4:0]] : 8'h00;
  assign CRT_TIMING_0 = crt_val[0];

  // io read data, one cycle after the strobe
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      IO_RDATA  <= 8'h00;
      IO_RVALID <= 1'b0;
    end else begin
      IO_RVALID <= IO_RD;
      if (IO_RD) begin
        if (IO_ADDR == `GHC_MISC_RD_PORT) begin
          IO_RDATA <= misc_q;
        end else if (idx_hit) begin
          IO_RDATA <= crt_idx_q;
        end else if (dat_hit) begin
          IO_RDATA <= crt_rd;
        end else if (sts_hit) begin
          IO_RDATA <= DISP_STATUS;
        end else begin
          IO_RDATA <= 8'h00;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // memory decode and register window
  // ------------------------------------------------------------
  // ring pointer words held in the window
  localparam RING_WORDS = 4;

  // window registers and offset decodes
  reg  [31:0] ring_q [0:RING_WORDS-1];
  reg  [31:0] cursor_q;
  wire [18:0] mm_ofs;
  wire        ring_hit;
  wire        cursor_hit;
  wire [1:0]  ring_sel;
  wire        fb_hit64;
  wire        fb_hit32;

  assign MMIO_HIT = (MEM_ADDR[31:`GHC_MMIO_BASE_LSB] == mmio_base_q);
  assign mm_ofs   = MEM_ADDR[18:0];
  assign ring_hit = (mm_ofs[18:4] == `GHC_RING_OFS >> 4);
  assign cursor_hit = (mm_ofs == `GHC_CURSOR_OFS);
  assign ring_sel = mm_ofs[3:2];
  assign fb_hit64 = (MEM_ADDR[31:`GHC_FB64_LSB] == fb_base_q[31:`GHC_FB64_LSB]);
  assign fb_hit32 = fb_hit64 & (MEM_ADDR[`GHC_FB32_LSB] == fb_base_q[`GHC_FB32_LSB]);
  assign FB_HIT   = ap64 ? fb_hit64 : fb_hit32;
  assign FB_OFFSET = {MEM_ADDR[25] & ap64, MEM_ADDR[24:0]};

  // cursor fetches go straight to physical memory
  assign CURSOR_FETCH_ADDR = cursor_q;

  // window register writes
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      cursor_q  <= `GHC_WIN_RST;
      ring_q[0] <= `GHC_WIN_RST;
      ring_q[1] <= `GHC_WIN_RST;
      ring_q[2] <= `GHC_WIN_RST;
      ring_q[3] <= `GHC_WIN_RST;
    end else if (MEM_WR & MMIO_HIT) begin
      if (cursor_hit) begin
        cursor_q <= MEM_WDATA;
      end
      if (ring_hit) begin
        ring_q[ring_sel] <= MEM_WDATA;
      end
    end
  end

  // window read data; unmapped offsets read zero
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      MEM_RDATA  <= 32'h0000_0000;
      MEM_RVALID <= 1'b0;
    end else begin
      MEM_RVALID <= MEM_RD & MMIO_HIT;
      if (MEM_RD & MMIO_HIT) begin
        if (cursor_hit) begin
          MEM_RDATA <= cursor_q;
        end else if (ring_hit) begin
          MEM_RDATA <= ring_q[ring_sel];
        end else begin
          MEM_RDATA <= 32'h0000_0000;
        end
      end
    end
  end

endmodule // ghc_host_cfg
`default_nettype wire

// ==== ghc_host_cfg_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// --------------------------------
// host config decode checker
// --------------------------------
module ghc_host_cfg_props #(
  parameter [15:0] VENDOR_ID = 16'h1d0e, // arbitrary value
  parameter [15:0] DEVICE_ID = 16'h0a01  // arbitrary value
) (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  // config bus
  input wire logic [7:0]  CFG_ADDR,
  input wire logic        CFG_WR,
  input wire logic        CFG_RD,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  // io bus
  input wire logic [15:0] IO_ADDR,
  input wire logic        IO_WR,
  input wire logic [7:0]  IO_WDATA,
  input wire logic        IO_HIT,
  input wire logic        COLOR_MODE,
  // memory bus
  input wire logic [31:0] MEM_ADDR,
  input wire logic        MEM_WR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic        MMIO_HIT,
  input wire logic        FB_HIT,
  input wire logic [25:0] FB_OFFSET,
  input wire logic        MEM_FREQ_133,
  input wire logic [31:0] CURSOR_FETCH_ADDR
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  logic [12:0] win_q;
  // strap held long enough to cross the synchroniser
  sequence strap_steady;
    $stable(MEM_FREQ_133) [*4];
  endsequence
  // shadow of the window base
  always_ff @(posedge MCLK) begin
    if (SYS_RST)
      win_q <= 13'h0;
    else if (CFG_WR && CFG_ADDR == 8'h14)
      win_q <= CFG_WDATA[31:19];
  end
  chk_id_read_only: assert property ((CFG_RD && CFG_ADDR == 8'h00) |=> CFG_RDATA == {DEVICE_ID, VENDOR_ID})
    else $error("identity word wrong");
  chk_freq_strap_bit: assert property (strap_steady ##0 (CFG_RD && CFG_ADDR == 8'h50)
    |=> CFG_RDATA[4] == $past(MEM_FREQ_133)) else $error("frequency bit wrong");
  chk_mono_status_port: assert property ((IO_ADDR == 16'h03ba) |-> IO_HIT == !COLOR_MODE)
    else $error("mono status decode wrong");
  chk_color_status_port: assert property ((IO_ADDR == 16'h03da) |-> IO_HIT == COLOR_MODE)
    else $error("colour status decode wrong");
  chk_mode_select_write: assert property ((IO_WR && IO_ADDR == 16'h03c2) |=> COLOR_MODE == $past(IO_WDATA[0]))
    else $error("mode bit not loaded");
  chk_window_decode: assert property (MMIO_HIT == (MEM_ADDR[31:19] == win_q))
    else $error("window decode wrong");
  chk_cursor_base_load: assert property ((MEM_WR && MMIO_HIT && MEM_ADDR[18:0] == 19'h70084)
    |=> CURSOR_FETCH_ADDR == $past(MEM_WDATA)) else $error("cursor base not loaded");
  chk_aperture_offset: assert property (FB_HIT |-> FB_OFFSET[24:0] == MEM_ADDR[24:0])
    else $error("aperture offset wrong");
endmodule // ghc_host_cfg_props
bind ghc_host_cfg ghc_host_cfg_props #(.VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID)) i_ghc_host_cfg_props (
  .MCLK(MCLK),
  .SYS_RST(SYS_RST),
  .CFG_ADDR(CFG_ADDR),
  .CFG_WR(CFG_WR),
  .CFG_RD(CFG_RD),
  .CFG_WDATA(CFG_WDATA),
  .CFG_RDATA(CFG_RDATA),
  .IO_ADDR(IO_ADDR),
  .IO_WR(IO_WR),
  .IO_WDATA(IO_WDATA),
  .IO_HIT(IO_HIT),
  .COLOR_MODE(COLOR_MODE),
  .MEM_ADDR(MEM_ADDR),
  .MEM_WR(MEM_WR),
  .MEM_WDATA(MEM_WDATA),
  .MMIO_HIT(MMIO_HIT),
  .FB_HIT(FB_HIT),
  .FB_OFFSET(FB_OFFSET),
  .MEM_FREQ_133(MEM_FREQ_133),
  .CURSOR_FETCH_ADDR(CURSOR_FETCH_ADDR)
);
`default_nettype wire

// ==== ghc_testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
// --------------------------------
// host config decode testbench
// --------------------------------
module testbench;
  // design inputs and outputs
  logic        MCLK = 0, SYS_RST = 1, CFG_WR = 0, CFG_RD = 0, IO_WR = 0, IO_RD = 0, MEM_WR = 0, MEM_RD = 0;
  logic        MEM_FREQ_133 = 0;
  logic [7:0]  CFG_ADDR = 0, IO_WDATA = 0, DISP_STATUS = 0, o, v;
  logic [15:0] IO_ADDR = 0;
  logic [31:0] CFG_WDATA = 0, MEM_ADDR = 0, MEM_WDATA = 0, q, w, base, ring [4];
  wire  [31:0] CFG_RDATA, MEM_RDATA, CURSOR_FETCH_ADDR;
  wire  [25:0] FB_OFFSET;
  wire  [7:0]  IO_RDATA, CRT_TIMING_0;
  wire         CFG_RVALID, IO_RVALID, MEM_RVALID, IO_HIT, MMIO_HIT, FB_HIT, COLOR_MODE;
  int          bad_count = 0, n_compared = 0;

  ghc_host_cfg i_ghc_host_cfg (
    .MCLK(MCLK),
    .SYS_RST(SYS_RST),
    .CFG_ADDR(CFG_ADDR),
    .CFG_WR(CFG_WR),
    .CFG_RD(CFG_RD),
    .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(CFG_RDATA),
    .CFG_RVALID(CFG_RVALID),
    .IO_ADDR(IO_ADDR),
    .IO_WR(IO_WR),
    .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA),
    .IO_RDATA(IO_RDATA),
    .IO_RVALID(IO_RVALID),
    .IO_HIT(IO_HIT),
    .DISP_STATUS(DISP_STATUS),
    .MEM_ADDR(MEM_ADDR),
    .MEM_WR(MEM_WR),
    .MEM_RD(MEM_RD),
    .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA),
    .MEM_RVALID(MEM_RVALID),
    .MMIO_HIT(MMIO_HIT),
    .FB_HIT(FB_HIT),
    .FB_OFFSET(FB_OFFSET),
    .MEM_FREQ_133(MEM_FREQ_133),
    .CURSOR_FETCH_ADDR(CURSOR_FETCH_ADDR),
    .COLOR_MODE(COLOR_MODE),
    .CRT_TIMING_0(CRT_TIMING_0)
  );

  // expected ports and aperture offset, from the decode rules
  function automatic logic [15:0] ctl_port(input int m);
    return m ? 16'h03d4 : 16'h03b4;
  endfunction
  function automatic logic [15:0] sts_port(input int m);
    return m ? 16'h03da : 16'h03ba;
  endfunction
  function automatic logic [25:0] fb_ofs(input logic [31:0] a, input logic big);
    return big ? a[25:0] : {1'b0, a[24:0]};
  endfunction

  // clock
  initial forever #4 MCLK = ~MCLK;

  // compare one value
  task automatic cmp(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // verdict and end of run
  task automatic close_out;
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one access: b 0 config, 1 io, 2 memory, 3 address only
  task automatic acc(input int b, input logic wr, input logic [31:0] a, d);
    @(posedge MCLK);
    {CFG_ADDR, IO_ADDR, MEM_ADDR} <= {a[7:0], a[15:0], a};
    {CFG_WDATA, IO_WDATA, MEM_WDATA} <= {d, d[7:0], d};
    {CFG_WR, CFG_RD, IO_WR, IO_RD, MEM_WR, MEM_RD} <= 6'h20 >> (2 * b + !wr);
    DISP_STATUS <= 8'($urandom);
    @(posedge MCLK);
    {CFG_WR, CFG_RD, IO_WR, IO_RD, MEM_WR, MEM_RD} <= 6'h0;
    #1 q = b == 0 ? CFG_RDATA : b == 1 ? {24'h0, IO_RDATA} : MEM_RDATA;
    if (b == 0) cmp("cfg read valid", !wr, CFG_RVALID);
    if (b == 1) cmp("io read valid", !wr, IO_RVALID);
    if (b == 2) cmp("window read valid", !wr, MEM_RVALID);
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h5ae8));
    repeat (5) @(posedge MCLK);
    SYS_RST <= 0;
    acc(0, 0, 8'h00, 0);
    cmp("ids", 32'h0a01_1d0e, q);
    acc(0, 1, 8'h00, $urandom);
    acc(0, 0, 8'h00, 0);
    cmp("ids kept", 32'h0a01_1d0e, q);
    for (int f = 0; f < 2; f++) begin
      @(posedge MCLK);
      MEM_FREQ_133 <= f[0];
      repeat (4) @(posedge MCLK);
      acc(0, 1, 8'h50, {27'h0, !f[0], 4'h0});
      acc(0, 0, 8'h50, 0);
      cmp("freq bit", f, q[4]);
    end
    base = $urandom & 32'h7ff8_0000;
    acc(0, 1, 8'h14, base | 32'h0007_ffff);
    acc(0, 0, 8'h14, 0);
    cmp("window base", base, q);
    w = $urandom;
    acc(2, 1, base + 32'h70084, w);
    cmp("cursor out", w, CURSOR_FETCH_ADDR);
    acc(2, 1, base + 32'hf0084, ~w);
    acc(2, 0, base + 32'h70084, 0);
    cmp("cursor kept", w, q);
    for (int i = 0; i < 8; i++) begin
      if (i < 4) ring[i] = $urandom;
      acc(2, i < 4, base + 32'h2030 + 4 * (i % 4), ring[i % 4]);
      if (i > 3) cmp("ring word", ring[i % 4], q);
    end
    acc(0, 1, 8'h10, 32'hfe00_0000);
    w = $urandom & 32'h01ff_ffff;
    acc(3, 0, 32'hfe00_0000 | w, 0);
    cmp("fb offset 32", fb_ofs(32'hfe00_0000 | w, 0), FB_OFFSET);
    cmp("fb hit 32", 1, FB_HIT);
    acc(3, 0, 32'hfd00_0000 | w, 0);
    cmp("fb miss 32", 0, FB_HIT);
    acc(0, 1, 8'h50, 32'h1);
    acc(3, 0, 32'hfd00_0000 | w, 0);
    cmp("fb offset 64", fb_ofs(32'hfd00_0000 | w, 1), FB_OFFSET);
    cmp("fb hit 64", 1, FB_HIT);
    for (int m = 0; m < 2; m++) begin
      acc(1, 1, 16'h03c2, m);
      acc(1, 0, 16'h03cc, 0);
      cmp("mode readback", m, q[0]);
      acc(1, 0, sts_port(m), 0);
      cmp("status port", DISP_STATUS, q);
      acc(3, 0, ctl_port(1 - m), 0);
      cmp("idle mode port", 0, IO_HIT);
      w = ctl_port(m);
      o = CRT_TIMING_0;
      v = ~o;
      acc(1, 1, w, 8'h11);
      acc(1, 1, w + 1, 8'h80);
      acc(1, 1, w, 8'h00);
      acc(1, 1, w + 1, v);
      cmp("locked write", o, CRT_TIMING_0);
      acc(1, 1, w, 8'h11);
      acc(1, 0, w + 1, 0);
      cmp("unlock read", 8'h80, q);
      acc(1, 1, w + 1, q & 8'h7f);
      acc(1, 1, w, 8'h00);
      acc(1, 1, w + 1, v);
      cmp("unlocked write", v, CRT_TIMING_0);
    end
    close_out;
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge MCLK);
    bad_count++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
